// file: design/dbu_pkg.sv
package dbu_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_CMD      = 12'h000;
    localparam logic [11:0] OFF_LINE_CFG = 12'h004;
    localparam logic [11:0] OFF_IRQ_SET  = 12'h008;
    localparam logic [11:0] OFF_IRQ_CLR  = 12'h00c;
    localparam logic [11:0] OFF_IRQ_VIEW = 12'h010;
    localparam logic [11:0] OFF_FLAGS    = 12'h014;
    localparam logic [11:0] OFF_RX_CHAR  = 12'h018;
    localparam logic [11:0] OFF_TX_CHAR  = 12'h01c;
    localparam logic [11:0] OFF_DIVISOR  = 12'h020;
    localparam logic [11:0] OFF_PART_ID  = 12'h040;
    localparam logic [11:0] OFF_PART_EXT = 12'h044;
    localparam logic [11:0] OFF_LOCKOUT  = 12'h048;

    // command_strobes bit positions
    localparam int CMD_RX_RST  = 2;
    localparam int CMD_TX_RST  = 3;
    localparam int CMD_RX_ON   = 4;
    localparam int CMD_RX_OFF  = 5;
    localparam int CMD_TX_ON   = 6;
    localparam int CMD_TX_OFF  = 7;
    localparam int CMD_CLR_ERR = 8;

    // line_configuration fields and reset value
    localparam int          CFG_CHECK_LSB = 9;
    localparam int          CFG_LOOP_LSB  = 14;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    localparam logic [1:0]  LOOP_NORMAL   = 2'h0;
    localparam logic [1:0]  LOOP_ECHO     = 2'h1;
    localparam logic [1:0]  LOOP_LOCAL    = 2'h2;
    localparam logic [1:0]  LOOP_REMOTE   = 2'h3;

    // shared layout of event_flags and the three mask registers
    localparam int          ST_RX_AVAIL  = 0;
    localparam int          ST_TX_FREE   = 1;
    localparam int          ST_RX_END    = 3;
    localparam int          ST_TX_END    = 4;
    localparam int          ST_OVERRUN   = 5;
    localparam int          ST_FRAME     = 6;
    localparam int          ST_CHECK     = 7;
    localparam int          ST_TX_IDLE   = 9;
    localparam int          ST_TX_BUFE   = 11;
    localparam int          ST_RX_BUFF   = 12;
    localparam int          ST_DBG_OUT   = 30;
    localparam int          ST_DBG_IN    = 31;
    localparam logic [31:0] ST_MASK      = 32'hc000_1afb;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [7:0]  RX_CHAR_RST  = 8'h00;
    localparam logic [15:0] DIV_RESET    = 16'h0000;
    localparam logic        LOCK_RESET   = 1'b0;
    localparam int          LOCK_BIT     = 0;

    // serial timing: sixteen sample ticks per bit, middle at eight
    localparam logic [3:0]  SUB_LAST     = 4'hf;
    localparam logic [3:0]  SUB_HALF     = 4'h7;

    localparam logic [1:0]  AXI_OKAY     = 2'h0;

    typedef struct packed {
        logic [7:0] data;
        logic       check_err;
        logic       frame_err;
    } dbu_rx_char_t;

    // check bit for a character; callers skip it when the type msb is set
    function automatic logic dbu_check_bit(input logic [2:0] kind, input logic [7:0] d);
        logic r;
        r = 1'b0;
        unique case (kind[1:0])
            2'h0: r = ^d;
            2'h1: r = ~^d;
            2'h2: r = 1'b0;
            2'h3: r = 1'b1;
        endcase
        return r;
    endfunction

endpackage

// file: design/dbu_rx.sv
`timescale 1ns/1ns
module dbu_rx import dbu_pkg::*; (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       abort,
    input  wire logic       tick,
    input  wire logic       allow_start,
    input  wire logic       line,
    input  wire logic [2:0] check_type,
    output dbu_rx_char_t    char_out,
    output logic            char_done,
    output logic            busy
);
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } dbu_rx_state_t;

    dbu_rx_state_t state_r;
    logic [3:0]    sub_r;
    logic [3:0]    idx_r;
    logic [8:0]    shf_r;
    logic          has_chk;
    logic [7:0]    got;

    assign has_chk = ~check_type[2];
    assign got     = has_chk ? shf_r[7:0] : shf_r[8:1];
    assign busy    = state_r != RX_IDLE;

    always_ff @(posedge aclk) begin
        char_done <= 1'b0;
        if (!aresetn || abort) begin
            state_r  <= RX_IDLE;
            sub_r    <= 4'h0;
            idx_r    <= 4'h0;
            shf_r    <= 9'h000;
            char_out <= '0;
        end else if (tick) begin
            sub_r <= sub_r + 4'h1;
            unique case (state_r)
                RX_IDLE: begin
                    sub_r <= 4'h0;
                    if (allow_start && !line) begin
                        state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (sub_r == SUB_HALF) begin
                        // a start bit gone high by mid-bit was a glitch
                        state_r <= line ? RX_IDLE : RX_DATA;
                        sub_r   <= 4'h0;
                        idx_r   <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (sub_r == SUB_LAST) begin
                        shf_r <= {line, shf_r[8:1]};
                        idx_r <= idx_r + 4'h1;
                        if (idx_r == (has_chk ? 4'h8 : 4'h7)) begin
                            state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (sub_r == SUB_LAST) begin
                        char_done          <= 1'b1;
                        char_out.data      <= got;
                        char_out.frame_err <= ~line;
                        char_out.check_err <= has_chk && (shf_r[8] != dbu_check_bit(check_type, got));
                        state_r            <= RX_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // dbu_rx

// file: design/dbu_top.sv
`timescale 1ns/1ns
module dbu_top import dbu_pkg::*; #(
    parameter int          ADDR_W   = 12,
    parameter logic [31:0] PART_ID  = 32'h8000_0001, // arbitrary value
    parameter logic [31:0] PART_EXT = 32'h0000_0002  // arbitrary value
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_in_pin,
    output logic                   serial_out_pin,
    input  wire logic              rx_dma_end,
    input  wire logic              tx_dma_end,
    input  wire logic              tx_dma_buffer_empty,
    input  wire logic              rx_dma_buffer_full,
    input  wire logic              debug_channel_inbound_full,
    input  wire logic              debug_channel_outbound_full,
    output logic                   irq
);
    // write channel holding registers
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic              wr_go;
    logic [31:0]       wd;
    logic [11:0]       wa;
    logic              rd_go;
    logic [11:0]       ra;

    // register state
    logic [31:0]       cfg_r;
    logic [31:0]       mask_r;
    logic [15:0]       div_r;
    logic              lock_r;
    logic [7:0]        rx_char_r;
    logic [7:0]        hold_r;
    logic              hold_full_r;
    logic              rx_en_r;
    logic              rx_stop_r;
    logic              tx_en_r;
    logic              tx_drain_r;
    logic              rx_avail_r;
    logic              ovr_r;
    logic              frm_r;
    logic              chk_r;
    logic [31:0]       flags;

    // serial side
    logic [1:0]        pin_sync_r;
    logic [15:0]       div_cnt_r;
    logic              tick_r;
    logic              rx_line;
    logic              rx_done;
    logic              rx_busy;
    dbu_rx_char_t      rx_got;
    logic              tx_line;
    logic              tx_busy;
    logic              tx_load;
    logic              cmd_wr;
    logic              rx_rst;
    logic              tx_rst;
    logic              clr_err;
    logic              rx_chr_rd;
    logic [2:0]        check_type;
    logic [1:0]        loop_sel;
    logic              remote_mode;

    assign check_type  = cfg_r[CFG_CHECK_LSB +: 3];
    assign loop_sel    = cfg_r[CFG_LOOP_LSB +: 2];
    assign remote_mode = loop_sel == LOOP_REMOTE;

    // AXI4-Lite write: address and data taken in either order
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wa    = 12'({aw_addr_r[ADDR_W-1:2], 2'b00});
    assign wd    = w_data_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                // disabled byte lanes act as zeros, which only the command and interrupt set/clear registers ignore
                w_data_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_bresp = AXI_OKAY;

    // AXI4-Lite read: one cycle from address to data
    assign rd_go     = s_axi_arvalid && s_axi_arready;
    assign ra        = 12'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    assign rx_chr_rd = rd_go && ra == OFF_RX_CHAR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                unique case (ra)
                    OFF_LINE_CFG: s_axi_rdata <= cfg_r;
                    OFF_IRQ_VIEW: s_axi_rdata <= mask_r;
                    OFF_FLAGS:    s_axi_rdata <= flags;
                    OFF_RX_CHAR:  s_axi_rdata <= {24'h000000, rx_char_r};
                    OFF_DIVISOR:  s_axi_rdata <= {16'h0000, div_r};
                    OFF_PART_ID:  s_axi_rdata <= PART_ID;
                    OFF_PART_EXT: s_axi_rdata <= PART_ID[31] ? PART_EXT : 32'h0000_0000;
                    OFF_LOCKOUT:  s_axi_rdata <= {31'h0000_0000, lock_r};
                    default:      s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_rresp = AXI_OKAY;

    // command decode
    assign cmd_wr  = wr_go && wa == OFF_CMD;
    assign rx_rst  = cmd_wr && wd[CMD_RX_RST];
    assign tx_rst  = cmd_wr && wd[CMD_TX_RST];
    assign clr_err = cmd_wr && wd[CMD_CLR_ERR];
    assign tx_load = hold_full_r && !tx_busy && (tx_en_r || tx_drain_r) && !remote_mode;

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r  <= CFG_RESET;
            div_r  <= DIV_RESET;
            lock_r <= LOCK_RESET;
            mask_r <= MASK_RESET;
        end else if (wr_go) begin
            if (wa == OFF_LINE_CFG) begin
                cfg_r <= wd & ((32'h0000_0007 << CFG_CHECK_LSB) | (32'h0000_0003 << CFG_LOOP_LSB));
            end
            if (wa == OFF_DIVISOR) begin
                div_r <= wd[15:0];
            end
            if (wa == OFF_LOCKOUT) begin
                lock_r <= wd[LOCK_BIT];
            end
            if (wa == OFF_IRQ_SET) begin
                mask_r <= mask_r | (wd & ST_MASK);
            end
            if (wa == OFF_IRQ_CLR) begin
                mask_r <= mask_r & ~(wd & ST_MASK);
            end
        end
    end

    // receiver enable; an off command lets a running character complete
    always_ff @(posedge aclk) begin
        if (!aresetn || rx_rst) begin
            rx_en_r   <= 1'b0;
            rx_stop_r <= 1'b0;
        end else if (cmd_wr && wd[CMD_RX_OFF]) begin
            rx_en_r   <= 1'b0;
            rx_stop_r <= rx_busy;
        end else if (cmd_wr && wd[CMD_RX_ON]) begin
            rx_en_r   <= 1'b1;
            rx_stop_r <= 1'b0;
        end else if (!rx_busy) begin
            rx_stop_r <= 1'b0;
        end
    end

    // transmitter enable; an off command drains shifter and holding register
    always_ff @(posedge aclk) begin
        if (!aresetn || tx_rst) begin
            tx_en_r    <= 1'b0;
            tx_drain_r <= 1'b0;
        end else if (cmd_wr && wd[CMD_TX_OFF]) begin
            tx_en_r    <= 1'b0;
            tx_drain_r <= tx_busy || hold_full_r;
        end else if (cmd_wr && wd[CMD_TX_ON]) begin
            tx_en_r    <= 1'b1;
            tx_drain_r <= 1'b0;
        end else if (!tx_busy && !hold_full_r) begin
            tx_drain_r <= 1'b0;
        end
    end

    // holding register; writes while the transmitter is off are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn || tx_rst) begin
            hold_full_r <= 1'b0;
            hold_r      <= 8'h00;
        end else if (wr_go && wa == OFF_TX_CHAR && tx_en_r) begin
            hold_full_r <= 1'b1;
            hold_r      <= wd[7:0];
        end else if (tx_load) begin
            hold_full_r <= 1'b0;
        end
    end

    // received character and sticky flags; a new event beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_char_r  <= RX_CHAR_RST;
            rx_avail_r <= 1'b0;
            ovr_r      <= 1'b0;
            frm_r      <= 1'b0;
            chk_r      <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_char_r  <= rx_got.data;
                rx_avail_r <= 1'b1;
            end else if (rx_chr_rd || rx_rst || (!rx_en_r && !rx_stop_r)) begin
                rx_avail_r <= 1'b0;
            end
            ovr_r <= (ovr_r && !clr_err) || (rx_done && rx_avail_r);
            frm_r <= (frm_r && !clr_err) || (rx_done && rx_got.frame_err);
            chk_r <= (chk_r && !clr_err) || (rx_done && rx_got.check_err);
        end
    end

    // event_flags assembly
    always_comb begin
        flags              = 32'h0000_0000;
        flags[ST_RX_AVAIL] = rx_avail_r;
        flags[ST_TX_FREE]  = tx_en_r && !hold_full_r;
        flags[ST_RX_END]   = rx_dma_end;
        flags[ST_TX_END]   = tx_dma_end;
        flags[ST_OVERRUN]  = ovr_r;
        flags[ST_FRAME]    = frm_r;
        flags[ST_CHECK]    = chk_r;
        flags[ST_TX_IDLE]  = tx_en_r && !hold_full_r && !tx_busy;
        flags[ST_TX_BUFE]  = tx_dma_buffer_empty;
        flags[ST_RX_BUFF]  = rx_dma_buffer_full;
        flags[ST_DBG_OUT]  = debug_channel_outbound_full;
        flags[ST_DBG_IN]   = debug_channel_inbound_full;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & mask_r);
        end
    end

    // sample tick: one pulse every divisor cycles, sixteen per bit; zero stops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r <= 16'h0000;
            tick_r    <= 1'b0;
        end else if (div_r == 16'h0000) begin
            div_cnt_r <= 16'h0000;
            tick_r    <= 1'b0;
        end else if (div_cnt_r >= div_r - 16'h0001) begin
            div_cnt_r <= 16'h0000;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
            tick_r    <= 1'b0;
        end
    end

    // pin synchroniser and channel routing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_r     <= 2'b11;
            serial_out_pin <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[0], serial_in_pin};
            unique case (loop_sel)
                LOOP_NORMAL: serial_out_pin <= tx_line;
                LOOP_ECHO:   serial_out_pin <= pin_sync_r[1];
                LOOP_LOCAL:  serial_out_pin <= 1'b1;
                LOOP_REMOTE: serial_out_pin <= pin_sync_r[1];
            endcase
        end
    end

    assign rx_line = (loop_sel == LOOP_LOCAL) ? tx_line : pin_sync_r[1];

    dbu_rx u_rx (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .abort       (rx_rst),
        .tick        (tick_r),
        .allow_start (rx_en_r && !remote_mode),
        .line        (rx_line),
        .check_type  (check_type),
        .char_out    (rx_got),
        .char_done   (rx_done),
        .busy        (rx_busy)
    );

    dbu_tx u_tx (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .abort      (tx_rst),
        .tick       (tick_r),
        .load       (tx_load),
        .load_data  (hold_r),
        .check_type (check_type),
        .line       (tx_line),
        .busy       (tx_busy)
    );
endmodule // dbu_top

// file: design/dbu_tx.sv
`timescale 1ns/1ns
module dbu_tx import dbu_pkg::*; (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       abort,
    input  wire logic       tick,
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    input  wire logic [2:0] check_type,
    output logic            line,
    output logic            busy
);
    logic [10:0] frame_r;
    logic [3:0]  left_r;
    logic [3:0]  sub_r;

    assign busy = left_r != 4'h0;
    assign line = busy ? frame_r[0] : 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn || abort) begin
            frame_r <= 11'h7ff;
            left_r  <= 4'h0;
            sub_r   <= 4'h0;
        end else if (load && !busy) begin
            // start, eight data bits lsb first, optional check, stop
            if (check_type[2]) begin
                frame_r <= {2'b11, load_data, 1'b0};
                left_r  <= 4'ha;
            end else begin
                frame_r <= {1'b1, dbu_check_bit(check_type, load_data), load_data, 1'b0};
                left_r  <= 4'hb;
            end
            sub_r <= 4'h0;
        end else if (tick && busy) begin
            sub_r <= sub_r + 4'h1;
            if (sub_r == SUB_LAST) begin
                frame_r <= {1'b1, frame_r[10:1]};
                left_r  <= left_r - 4'h1;
            end
        end
    end
endmodule // dbu_tx

// file: verification/dbu_peer.sv
`timescale 1ns/1ns
module dbu_peer (
    input wire logic aclk,
    input wire logic rx,
    output logic     line
);
    initial line = 1'b1;
    // start, data lsb first, check, stop; long idle gap so a low stop cannot alias a start
    task automatic send(input logic [7:0] b, input logic c, input logic s);
        logic [10:0] f;
        f = {s, c, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (16) @(posedge aclk);
        end
        line <= 1'b1;
        repeat (192) @(posedge aclk);
    endtask
    // mid-bit samples after a falling edge: start, eight data lsb first, then the tenth bit
    task automatic take(output logic [9:0] f);
        @(negedge rx);
        repeat (8) @(posedge aclk);
        f[0] = rx;
        for (int i = 1; i < 10; i++) begin
            repeat (16) @(posedge aclk);
            f[i] = rx;
        end
    endtask
endmodule // dbu_peer

// file: verification/dbu_top_assertions.sv
`timescale 1ns/1ns
module dbu_top_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic serial_out_pin,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_done; s_axi_rvalid && s_axi_rready; endsequence
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid) else $error("read not answered");
    read_single_a: assert property (r_done |=> !s_axi_rvalid) else $error("read data repeated");
    ar_return_a: assert property (r_done |=> !s_axi_arready ##1 s_axi_arready) else $error("arready timing");
    ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during read");
    write_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    line_idle_a: assert property ($rose(aresetn) |-> serial_out_pin) else $error("line not idle high");
    line_bits_a: assert property ($fell(serial_out_pin) |-> !serial_out_pin [*8]) else $error("short low bit");
    irq_quiet_a: assert property ($rose(aresetn) |-> !irq) else $error("irq after reset");
endmodule // dbu_top_assertions
bind dbu_top dbu_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .serial_out_pin(serial_out_pin), .irq(irq));

// file: verification/dbu_top_bench.sv
`timescale 1ns/1ns
module dbu_top_bench;
import dbu_pkg::*;
logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
logic [11:0] aw = 0, ar = 0;
logic [31:0] wd = 0, d, rdat;
logic [5:0]  ext = 0;
logic [9:0]  f;
logic [1:0]  brs, rrs;
logic        awr, wrd, bv, arr, rv, sin, sout, irq;
int          fail_count = 0, total_checks = 0, cyc = 0;
initial forever #25 aclk = ~aclk;
dbu_peer peer (.aclk(aclk), .rx(sout), .line(sin));
dbu_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry), .serial_in_pin(sin), .serial_out_pin(sout),
    .rx_dma_end(ext[0]), .tx_dma_end(ext[1]), .tx_dma_buffer_empty(ext[2]), .rx_dma_buffer_full(ext[3]),
    .debug_channel_inbound_full(ext[4]), .debug_channel_outbound_full(ext[5]), .irq(irq));
task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
        fail_count++;
        $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] v);
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
        @(posedge aclk);
        if (awr) awv <= 0;
        if (wrd) wv <= 0;
    end while (bv !== 1'b1);
    chk(brs, AXI_OKAY);
endtask
task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    ar <= a;
    arv <= 1;
    rry <= 1;
    do begin
        @(posedge aclk);
        if (arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rdat;
    chk(rrs, AXI_OKAY);
    chk(d & m, e);
endtask
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        fail_count++;
        end_of_test();
    end
end
initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(OFF_LINE_CFG, '1, CFG_RESET);
    rc(12'h024, '1, 0);
    wr(OFF_IRQ_SET, 32'h8000_0003);
    wr(OFF_IRQ_CLR, 32'h0000_0001);
    rc(OFF_IRQ_VIEW, '1, 32'h8000_0002);
    ext <= 6'h3f;
    rc(OFF_FLAGS, 32'hc000_1818, 32'hc000_1818);
    chk(irq, 1);
    ext <= 0;
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    $display("registers done");
    wr(OFF_DIVISOR, 1);
    wr(OFF_CMD, 32'h10);
    peer.send(8'ha5, 0, 1);
    rc(OFF_RX_CHAR, '1, 32'ha5);
    rc(OFF_FLAGS, 32'he1, 0);
    peer.send(8'h5a, 1, 1);
    peer.send(8'h00, 0, 1);
    rc(OFF_FLAGS, 32'he1, 32'ha1);
    peer.send(8'h81, 0, 0);
    rc(OFF_FLAGS, 32'he0, 32'he0);
    wr(OFF_CMD, 32'h100);
    rc(OFF_FLAGS, 32'he0, 0);
    wr(OFF_LINE_CFG, 32'hffff_ffff);
    rc(OFF_LINE_CFG, '1, 32'h0000_ce00);
    fork
        peer.send(8'h69, 1, 1);
        peer.take(f);
    join
    chk(f, 10'h2d2);
    wr(OFF_LINE_CFG, 32'h0000_0800);
    peer.send(8'h96, 1, 1);
    rc(OFF_RX_CHAR, '1, 32'h96);
    rc(OFF_FLAGS, 32'he0, 32'h20);
    fork
        peer.send(8'h3c, 1, 1);
        begin
            repeat (40) @(posedge aclk);
            wr(OFF_CMD, 32'h20);
        end
    join
    rc(OFF_RX_CHAR, '1, 32'h3c);
    wr(OFF_CMD, 32'h04);
    rc(OFF_FLAGS, 32'h1, 0);
    $display("receive done");
    wr(OFF_CMD, 32'h40);
    rc(OFF_FLAGS, 32'h202, 32'h202);
    fork
        peer.take(f);
        begin
            wr(OFF_TX_CHAR, 32'h3c);
            rc(OFF_FLAGS, 32'h200, 0);
        end
    join
    chk(f, 10'h278);
    repeat (200) @(posedge aclk);
    rc(OFF_FLAGS, 32'h202, 32'h202);
    wr(OFF_CMD, 32'h08);
    rc(OFF_FLAGS, 32'h202, 0);
    wr(OFF_CMD, 32'h40);
    fork
        begin
            peer.take(f);
            chk(f, 10'h386);
            peer.take(f);
            chk(f, 10'h2b4);
        end
        begin
            wr(OFF_TX_CHAR, 32'hc3);
            wr(OFF_TX_CHAR, 32'h5a);
            wr(OFF_CMD, 32'h80);
        end
    join
    rc(OFF_FLAGS, 32'h202, 0);
    $display("transmit done");
    end_of_test();
end
endmodule // dbu_top_bench
